// file: src/status_regs.vh
`ifndef STATUS_REGS_VH
`define STATUS_REGS_VH
// command codes delivered by the parser
`define CMD_W 5
`define CMD_ESE_SET 5'h00
`define CMD_ESE_QRY 5'h01
`define CMD_ESR_QRY 5'h02
`define CMD_OPC 5'h03
`define CMD_OPC_QRY 5'h04
`define CMD_RST 5'h05
`define CMD_SRE_SET 5'h06
`define CMD_SRE_QRY 5'h07
`define CMD_STB_QRY 5'h08
`define CMD_TRG 5'h09
`define CMD_DER_QRY 5'h0A
`define CMD_DFR_QRY 5'h0B
`define CMD_TIME_QRY 5'h0C
`define CMD_CHK_QRY 5'h0D
`define CMD_SET_INPUT 5'h0E
`define CMD_SET_OUTPUT 5'h0F
`define CMD_VERBOSE 5'h10
`define CMD_TERSE 5'h11
// argument limits
`define ARG_W 16
`define MASK_MAX 16'h00FF
`define INPUT_RANGE_MAX 16'h0001
`define OUTPUT_RANGE_MAX 16'h0005
`define OPC_REPLY 8'h01
// event latch bits
`define EV_OP_DONE 0
`define EV_REQ_CTRL 1
`define EV_QUERY_FAULT 2
`define EV_DEV_DEP 3
`define EV_EXEC_FAULT 4
`define EV_SYNTAX_FAULT 5
`define EV_KEY_PRESSED 6
`define EV_POWERUP 7
`define EV_RESET 8'h80
// summary status byte bits
`define SB_SECONDS_TICK 0
`define SB_OVERRANGE 1
`define SB_ROM_SUM_READY 2
`define SB_INPUT_NEARLY_FULL 3
`define SB_REPLY_WAITING 4
`define SB_EVENT_SUMMARY 5
`define SB_SERVICE_SUMMARY 6
`define SB_BAND_CHANGE 7
`define SB_SERVICE_CLEAR 8'hBF
// flag register widths
`define FAULT_BITS 4
`define BAND_BITS 3
// reset state of ranges and reply mode
`define RESET_INPUT_10V 1'b1
`define RESET_OUTPUT_RANGE 3'h0
`define RESET_VERBOSE 1'b0
// queues
`define QUEUE_DEPTH 256
`define QUEUE_LEVEL_W 9
`define HIGH_PERCENT 75
`define LOW_PERCENT 25
// timing
`define CLOCK_PERIOD_NS 10
`define TICK_PERIOD_NS 1000000000
`endif

// file: src/sync_bits.v
`timescale 1ns/10ps
`default_nettype none
module sync_bits #(
   parameter W = 1
) (
   // clock and reset
   input wire clk_i,
   input wire rstn_i,
   input wire ce_i,
   // data
   input wire [W-1:0] async_i,
   output reg [W-1:0] sync_o
);
   reg [W-1:0] stage_reg;
   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         stage_reg <= {W{1'b0}};
         sync_o <= {W{1'b0}};
      end
      else if (ce_i)
      begin
         stage_reg <= async_i;
         sync_o <= stage_reg;
      end
   end
endmodule // sync_bits
`default_nettype wire

// file: src/fill_hysteresis.v
`timescale 1ns/10ps
`include "status_regs.vh"
`default_nettype none
module fill_hysteresis #(
   parameter DEPTH = `QUEUE_DEPTH,
   parameter W = `QUEUE_LEVEL_W
) (
   // clock and reset
   input wire clk_i,
   input wire rstn_i,
   input wire ce_i,
   // queue fill level and flag
   input wire [W-1:0] level_i,
   output reg full_o
);
   localparam [W-1:0] HIGH_MARK = DEPTH * `HIGH_PERCENT / 100;
   localparam [W-1:0] LOW_MARK = DEPTH * `LOW_PERCENT / 100;
   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         full_o <= 1'b0;
      else if (ce_i)
      begin
         // set above the high mark, hold until below the low mark
         if (level_i > HIGH_MARK)
            full_o <= 1'b1;
         else if (level_i < LOW_MARK)
            full_o <= 1'b0;
      end
   end
endmodule // fill_hysteresis
`default_nettype wire

// file: src/remote_status_reporting.v
// Function
// - event_summary is set when event_latch AND event_enable_mask is non-zero.
// - event_enable_mask writes accept 0 to 255; larger values are an error.
// - reading event_latch returns its contents, then clears all bits not set in that same cycle.
// - op_done sets as soon as the operation complete command is parsed.
// - operation complete query replies with numeric 1.
// - reset selects 10 V input, 200 uA output, terse; masks untouched.
// - query_fault sets on read with no reply, or on output overflow.
// - exec_fault sets on out-of-range parameter or unexecutable valid message.
// - syntax_fault sets on syntax error, unknown header, trigger inside message.
// - key_pressed_flag sets whenever a front-panel key is pressed.
// - powerup_flag is set after power is applied.
// - request-control bit never set; device-dependent error bit stays zero.
// - seconds_tick sets each second, clears on time query.
// - rom_sum_ready sets once after power-on, clears on checksum query.
// - input_nearly_full sets above 75 percent, clears below 25 percent.
// - reply_waiting is held while the output queue holds a byte.
// - service_summary set when status byte AND service mask non-zero.
// - overrange_flag on out-of-limits attempt; band_change on new band.
// - service mask written 0 to 255; reads back with bit 6 zero.
// - status byte returned to status query and serial poll, bit 6 summary.
// - trigger starts nothing and sets exec_fault instead.
// - band_flags report low, medium, high band; bits 3 to 7 zero.
`timescale 1ns/10ps
`include "status_regs.vh"
`default_nettype none
module remote_status_reporting #(
   parameter TICK_CYCLES = `TICK_PERIOD_NS / `CLOCK_PERIOD_NS,
   parameter LEVEL_W = `QUEUE_LEVEL_W
) (
   // clock, reset, enable
   input wire CLOCK_I,
   input wire RSTN_I,
   input wire CE_I,
   // parsed commands
   input wire CMD_VALID_I,
   input wire [`CMD_W-1:0] CMD_CODE_I,
   input wire [`ARG_W-1:0] CMD_ARG_I,
   // parser and queue events
   input wire SYNTAX_ERR_I,
   input wire EXEC_ERR_I,
   input wire EMPTY_READ_I,
   input wire OUT_OVERFLOW_I,
   input wire GET_IN_MSG_I,
   input wire BUS_TRIGGER_I,
   input wire OVERRANGE_I,
   input wire ROM_SUM_DONE_I,
   // queue levels
   input wire [LEVEL_W-1:0] IN_LEVEL_I,
   input wire [LEVEL_W-1:0] OUT_COUNT_I,
   // front panel and analogue pins
   input wire KEY_PRESS_I,
   input wire [`FAULT_BITS-1:0] FAULT_PINS_I,
   input wire [`BAND_BITS-1:0] BAND_PINS_I,
   // serial poll
   input wire SPOLL_I,
   output reg [7:0] SPOLL_DATA_O,
   // reply to the output buffer
   output reg REPLY_VALID_O,
   output reg [7:0] REPLY_DATA_O,
   // service request open-drain pin
   output wire SRQ_O,
   output wire SRQ_OE_O,
   // instrument setup
   output reg INPUT_10V_O,
   output reg [2:0] OUTPUT_RANGE_O,
   output reg VERBOSE_O
);
   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function [7:0] low_byte;
      input [`ARG_W-1:0] arg;
      begin
         low_byte = arg[7:0];
      end
   endfunction

   function is_cmd;
      input valid;
      input [`CMD_W-1:0] code;
      input [`CMD_W-1:0] want;
      begin
         is_cmd = valid && (code == want);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   reg [7:0] event_latch_reg;
   reg [7:0] event_latch_next;
   reg [7:0] event_enable_mask_reg;
   reg [7:0] service_enable_mask_reg;
   reg seconds_tick_reg;
   reg overrange_reg;
   reg rom_sum_ready_reg;
   reg rom_sum_seen_reg;
   reg band_change_reg;
   reg key_prev_reg;
   reg [`BAND_BITS-1:0] band_prev_reg;
   reg [31:0] tick_count_reg;
   wire key_sync;
   wire [`FAULT_BITS-1:0] fault_sync;
   wire [`BAND_BITS-1:0] band_sync;
   wire input_nearly_full;
   wire reply_waiting;
   wire event_summary;
   wire service_summary;
   wire [7:0] fault_flags;
   wire [7:0] band_flags;
   wire [7:0] status_low;
   wire [7:0] summary_status_byte;
   wire tick_hit;
   wire key_rise;
   wire band_new;
   wire arg_over_mask;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and queue level watch
   sync_bits #(
      .W(1 + `FAULT_BITS + `BAND_BITS)
   ) u_sync (
      .clk_i(CLOCK_I),
      .rstn_i(RSTN_I),
      .ce_i(CE_I),
      .async_i({KEY_PRESS_I, FAULT_PINS_I, BAND_PINS_I}),
      .sync_o({key_sync, fault_sync, band_sync})
   );

   fill_hysteresis #(
      .DEPTH(`QUEUE_DEPTH),
      .W(LEVEL_W)
   ) u_in_fill (
      .clk_i(CLOCK_I),
      .rstn_i(RSTN_I),
      .ce_i(CE_I),
      .level_i(IN_LEVEL_I),
      .full_o(input_nearly_full)
   );

   ////////////////////////////////////////////////////////////////////////////
   // command decode
   wire c_ese_set = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_ESE_SET);
   wire c_ese_qry = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_ESE_QRY);
   wire c_esr_qry = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_ESR_QRY);
   wire c_opc = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_OPC);
   wire c_opc_qry = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_OPC_QRY);
   wire c_rst = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_RST);
   wire c_sre_set = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_SRE_SET);
   wire c_sre_qry = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_SRE_QRY);
   wire c_stb_qry = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_STB_QRY);
   wire c_trg = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_TRG);
   wire c_der_qry = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_DER_QRY);
   wire c_dfr_qry = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_DFR_QRY);
   wire c_time_qry = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_TIME_QRY);
   wire c_chk_qry = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_CHK_QRY);
   wire c_set_in = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_SET_INPUT);
   wire c_set_out = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_SET_OUTPUT);
   wire c_verbose = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_VERBOSE);
   wire c_terse = is_cmd(CMD_VALID_I, CMD_CODE_I, `CMD_TERSE);
   wire c_unknown = CMD_VALID_I && (CMD_CODE_I > `CMD_TERSE);

   assign arg_over_mask = (CMD_ARG_I > `MASK_MAX);
   wire in_bad = c_set_in && (CMD_ARG_I > `INPUT_RANGE_MAX);
   wire out_bad = c_set_out && (CMD_ARG_I > `OUTPUT_RANGE_MAX);
   wire mask_bad = (c_ese_set || c_sre_set) && arg_over_mask;
   wire exec_set = EXEC_ERR_I || in_bad || out_bad || mask_bad || c_trg
      || BUS_TRIGGER_I;

   ////////////////////////////////////////////////////////////////////////////
   // derived status
   assign key_rise = key_sync && !key_prev_reg;
   assign band_new = (band_sync != band_prev_reg) && (band_sync != {`BAND_BITS{1'b0}});
   assign tick_hit = (tick_count_reg == TICK_CYCLES - 1);
   assign reply_waiting = (OUT_COUNT_I != {LEVEL_W{1'b0}});
   assign event_summary = |(event_latch_reg & event_enable_mask_reg);
   assign fault_flags = {4'h0, fault_sync};
   assign band_flags = {5'h00, band_sync};

   assign status_low[`SB_SECONDS_TICK] = seconds_tick_reg;
   assign status_low[`SB_OVERRANGE] = overrange_reg;
   assign status_low[`SB_ROM_SUM_READY] = rom_sum_ready_reg;
   assign status_low[`SB_INPUT_NEARLY_FULL] = input_nearly_full;
   assign status_low[`SB_REPLY_WAITING] = reply_waiting;
   assign status_low[`SB_EVENT_SUMMARY] = event_summary;
   assign status_low[`SB_SERVICE_SUMMARY] = 1'b0;
   assign status_low[`SB_BAND_CHANGE] = band_change_reg;

   // bit 6 of the stored mask is always zero, so no feedback loop
   assign service_summary = |(status_low & service_enable_mask_reg);
   assign summary_status_byte = status_low | ({7'h00, service_summary} << `SB_SERVICE_SUMMARY);

   // open drain: pull low while service is wanted
   assign SRQ_O = 1'b0;
   assign SRQ_OE_O = service_summary;

   ////////////////////////////////////////////////////////////////////////////
   // event latch next value: sets win over the read clear
   always @*
   begin
      event_latch_next = event_latch_reg;
      if (c_esr_qry)
         event_latch_next = 8'h00;
      if (c_opc || c_opc_qry)
         event_latch_next[`EV_OP_DONE] = 1'b1;
      if (EMPTY_READ_I || OUT_OVERFLOW_I)
         event_latch_next[`EV_QUERY_FAULT] = 1'b1;
      if (exec_set)
         event_latch_next[`EV_EXEC_FAULT] = 1'b1;
      if (SYNTAX_ERR_I || c_unknown || GET_IN_MSG_I)
         event_latch_next[`EV_SYNTAX_FAULT] = 1'b1;
      if (key_rise)
         event_latch_next[`EV_KEY_PRESSED] = 1'b1;
      event_latch_next[`EV_REQ_CTRL] = 1'b0;
      event_latch_next[`EV_DEV_DEP] = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always @(posedge CLOCK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         event_latch_reg <= `EV_RESET;
         event_enable_mask_reg <= 8'h00;
         service_enable_mask_reg <= 8'h00;
         key_prev_reg <= 1'b0;
         band_prev_reg <= {`BAND_BITS{1'b0}};
      end
      else if (CE_I)
      begin
         event_latch_reg <= event_latch_next;
         key_prev_reg <= key_sync;
         band_prev_reg <= band_sync;
         if (c_ese_set && !arg_over_mask)
            event_enable_mask_reg <= low_byte(CMD_ARG_I);
         if (c_sre_set && !arg_over_mask)
            service_enable_mask_reg <= low_byte(CMD_ARG_I) & `SB_SERVICE_CLEAR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status byte sticky bits
   always @(posedge CLOCK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         tick_count_reg <= 32'h00000000;
         seconds_tick_reg <= 1'b0;
         rom_sum_ready_reg <= 1'b0;
         rom_sum_seen_reg <= 1'b0;
         overrange_reg <= 1'b0;
         band_change_reg <= 1'b0;
      end
      else if (CE_I)
      begin
         if (tick_hit)
            tick_count_reg <= 32'h00000000;
         else
            tick_count_reg <= tick_count_reg + 32'h00000001;
         if (tick_hit)
            seconds_tick_reg <= 1'b1;
         else if (c_time_qry)
            seconds_tick_reg <= 1'b0;
         if (ROM_SUM_DONE_I && !rom_sum_seen_reg)
         begin
            rom_sum_ready_reg <= 1'b1;
            rom_sum_seen_reg <= 1'b1;
         end
         else if (c_chk_qry)
            rom_sum_ready_reg <= 1'b0;
         if (OVERRANGE_I)
            overrange_reg <= 1'b1;
         else if (c_stb_qry || SPOLL_I)
            overrange_reg <= 1'b0;
         if (band_new)
            band_change_reg <= 1'b1;
         else if (c_stb_qry || SPOLL_I)
            band_change_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // instrument setup
   always @(posedge CLOCK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         INPUT_10V_O <= `RESET_INPUT_10V;
         OUTPUT_RANGE_O <= `RESET_OUTPUT_RANGE;
         VERBOSE_O <= `RESET_VERBOSE;
      end
      else if (CE_I)
      begin
         if (c_rst)
         begin
            INPUT_10V_O <= `RESET_INPUT_10V;
            OUTPUT_RANGE_O <= `RESET_OUTPUT_RANGE;
            VERBOSE_O <= `RESET_VERBOSE;
         end
         else
         begin
            if (c_set_in && !in_bad)
               INPUT_10V_O <= CMD_ARG_I[0];
            if (c_set_out && !out_bad)
               OUTPUT_RANGE_O <= CMD_ARG_I[2:0];
            if (c_verbose)
               VERBOSE_O <= 1'b1;
            if (c_terse)
               VERBOSE_O <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // replies and serial poll
   always @(posedge CLOCK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         REPLY_VALID_O <= 1'b0;
         REPLY_DATA_O <= 8'h00;
         SPOLL_DATA_O <= 8'h00;
      end
      else if (CE_I)
      begin
         REPLY_VALID_O <= c_ese_qry || c_esr_qry || c_opc_qry || c_sre_qry
            || c_stb_qry || c_der_qry || c_dfr_qry;
         if (c_ese_qry)
            REPLY_DATA_O <= event_enable_mask_reg;
         else if (c_esr_qry)
            REPLY_DATA_O <= event_latch_reg;
         else if (c_opc_qry)
            REPLY_DATA_O <= `OPC_REPLY;
         else if (c_sre_qry)
            REPLY_DATA_O <= service_enable_mask_reg & `SB_SERVICE_CLEAR;
         else if (c_stb_qry)
            REPLY_DATA_O <= summary_status_byte;
         else if (c_der_qry)
            REPLY_DATA_O <= fault_flags;
         else if (c_dfr_qry)
            REPLY_DATA_O <= band_flags;
         if (SPOLL_I)
            SPOLL_DATA_O <= summary_status_byte;
      end
   end
endmodule // remote_status_reporting
`default_nettype wire

// file: dv/status_sva.sv
`timescale 1ns/10ps
`include "status_regs.vh"
`default_nettype none
module status_sva #(
   parameter LEVEL_W = 9
) (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RSTN_I,
   input wire logic CE_I,
   // requests
   input wire logic CMD_VALID_I,
   input wire logic [`CMD_W-1:0] CMD_CODE_I,
   input wire logic SPOLL_I,
   input wire logic [LEVEL_W-1:0] OUT_COUNT_I,
   // answers
   input wire logic [7:0] SPOLL_DATA_O,
   input wire logic REPLY_VALID_O,
   input wire logic [7:0] REPLY_DATA_O,
   input wire logic SRQ_OE_O,
   input wire logic INPUT_10V_O,
   input wire logic [2:0] OUTPUT_RANGE_O,
   input wire logic VERBOSE_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RSTN_I);
   logic tk;
   logic qry;
   assign tk = CE_I && CMD_VALID_I;
   assign qry = tk && (CMD_CODE_I inside {`CMD_ESE_QRY, `CMD_ESR_QRY, `CMD_OPC_QRY,
      `CMD_SRE_QRY, `CMD_STB_QRY, `CMD_DER_QRY, `CMD_DFR_QRY});
   ////////////////////////////////////////////////////////////////////////////
   a_reply_on_query:
      assert property (qry |=> REPLY_VALID_O) else $error("query without reply");
   a_reply_only_query:
      assert property (CE_I && !qry |=> !REPLY_VALID_O) else $error("stray reply");
   a_opc_reply_one:
      assert property (tk && CMD_CODE_I == `CMD_OPC_QRY |=> REPLY_DATA_O == `OPC_REPLY)
      else $error("completion reply wrong");
   a_sre_bit_six:
      assert property (tk && CMD_CODE_I == `CMD_SRE_QRY |=> !REPLY_DATA_O[6])
      else $error("service mask bit 6 set");
   a_stb_summary:
      assert property (tk && CMD_CODE_I == `CMD_STB_QRY |=> REPLY_DATA_O[6] == $past(SRQ_OE_O))
      else $error("status bit 6 differs from request");
   a_poll_status:
      assert property (CE_I && SPOLL_I |=> SPOLL_DATA_O[6] == $past(SRQ_OE_O)
         && SPOLL_DATA_O[4] == ($past(OUT_COUNT_I) != 0)) else $error("poll byte wrong");
   a_esr_unused_bits:
      assert property (tk && CMD_CODE_I == `CMD_ESR_QRY |=> !REPLY_DATA_O[1] && !REPLY_DATA_O[3])
      else $error("unused event bit set");
   a_der_reserved:
      assert property (tk && CMD_CODE_I == `CMD_DER_QRY |=> REPLY_DATA_O[7:4] == 4'h0)
      else $error("fault reserved bits set");
   a_dfr_reserved:
      assert property (tk && CMD_CODE_I == `CMD_DFR_QRY |=> REPLY_DATA_O[7:3] == 5'h00)
      else $error("band reserved bits set");
   a_trg_exec_fault:
      assert property ((tk && CMD_CODE_I == `CMD_TRG) ##1 (tk && CMD_CODE_I == `CMD_ESR_QRY)
         |=> REPLY_DATA_O[4]) else $error("trigger without exec fault");
   a_rst_setup:
      assert property (tk && CMD_CODE_I == `CMD_RST |=> INPUT_10V_O
         && OUTPUT_RANGE_O == 3'h0 && !VERBOSE_O) else $error("reset setup wrong");
   c_poll: cover property (CE_I && SPOLL_I);
   c_srq: cover property ($rose(SRQ_OE_O));
   c_trg_read: cover property ((tk && CMD_CODE_I == `CMD_TRG) ##1 qry);
endmodule // status_sva
bind remote_status_reporting status_sva #(.LEVEL_W(LEVEL_W)) chk (.CLOCK_I(CLOCK_I),
   .RSTN_I(RSTN_I), .CE_I(CE_I), .CMD_VALID_I(CMD_VALID_I), .CMD_CODE_I(CMD_CODE_I),
   .SPOLL_I(SPOLL_I), .OUT_COUNT_I(OUT_COUNT_I), .SPOLL_DATA_O(SPOLL_DATA_O),
   .REPLY_VALID_O(REPLY_VALID_O), .REPLY_DATA_O(REPLY_DATA_O), .SRQ_OE_O(SRQ_OE_O),
   .INPUT_10V_O(INPUT_10V_O), .OUTPUT_RANGE_O(OUTPUT_RANGE_O), .VERBOSE_O(VERBOSE_O));
`default_nettype wire

// file: dv/bus_controller_model.sv
`timescale 1ns/10ps
`include "status_regs.vh"
`default_nettype none
module bus_controller_model (
   // clock
   input wire logic clk_i,
   // requests
   output logic cmd_valid_o,
   output logic [`CMD_W-1:0] cmd_code_o,
   output logic [`ARG_W-1:0] cmd_arg_o,
   output logic spoll_o,
   // answers
   input wire logic reply_valid_i,
   input wire logic [7:0] reply_data_i,
   input wire logic [7:0] spoll_data_i
);
   initial
   begin
      cmd_valid_o = 1'b0;
      cmd_code_o = 5'h1F;
      cmd_arg_o = 16'h0000;
      spoll_o = 1'b0;
   end
   // gap adds idle cycles; gap 0 still leaves one idle edge between commands
   task send(input logic [4:0] c, input logic [15:0] a, input int gap);
      repeat (gap) @(negedge clk_i);
      @(negedge clk_i);
      cmd_valid_o = 1'b1;
      cmd_code_o = c;
      cmd_arg_o = a;
      @(negedge clk_i);
      cmd_valid_o = 1'b0;
      // released lines never keep the last value
      cmd_code_o = ~cmd_code_o;
      cmd_arg_o = ~cmd_arg_o;
   endtask
   // the reply stands one cycle after the taking edge
   task ask(input logic [4:0] c, output logic [7:0] d, output logic ok);
      send(c, 16'h0000, 0);
      ok = reply_valid_i;
      d = reply_data_i;
   endtask
   // two commands on consecutive edges, the second one a query
   task pair(input logic [4:0] c1, input logic [4:0] c2, output logic [7:0] d,
      output logic ok);
      @(negedge clk_i);
      cmd_valid_o = 1'b1;
      cmd_code_o = c1;
      cmd_arg_o = 16'h0000;
      @(negedge clk_i);
      cmd_code_o = c2;
      @(negedge clk_i);
      cmd_valid_o = 1'b0;
      cmd_code_o = ~cmd_code_o;
      cmd_arg_o = ~cmd_arg_o;
      ok = reply_valid_i;
      d = reply_data_i;
   endtask
   task poll(output logic [7:0] d);
      @(negedge clk_i);
      spoll_o = 1'b1;
      @(negedge clk_i);
      spoll_o = 1'b0;
      d = spoll_data_i;
   endtask
endmodule // bus_controller_model
`default_nettype wire

// file: dv/tb_remote_status_reporting.sv
`timescale 1ns/10ps
`include "status_regs.vh"
`default_nettype none
module tb_remote_status_reporting;
   logic CLOCK_I, RSTN_I, CE_I, KEY_PRESS_I, cv, sp, rv, srq, srq_oe, in10, verb, ok;
   logic [4:0] cc;
   logic [15:0] ca;
   logic [7:0] ev, sd, rd, d;
   logic [8:0] IN_LEVEL_I, OUT_COUNT_I;
   logic [3:0] FAULT_PINS_I;
   logic [2:0] BAND_PINS_I, orng;
   int n_fail = 0;
   int total_checks = 0;
   localparam logic [47:0] EVX = {8'h10, 8'h20, 8'h04, 8'h04, 8'h10, 8'h20};
   remote_status_reporting #(.TICK_CYCLES(3000)) dut (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I),
      .CE_I(CE_I), .CMD_VALID_I(cv), .CMD_CODE_I(cc), .CMD_ARG_I(ca), .SYNTAX_ERR_I(ev[0]),
      .EXEC_ERR_I(ev[1]), .EMPTY_READ_I(ev[2]), .OUT_OVERFLOW_I(ev[3]), .GET_IN_MSG_I(ev[4]),
      .BUS_TRIGGER_I(ev[5]), .OVERRANGE_I(ev[6]), .ROM_SUM_DONE_I(ev[7]),
      .IN_LEVEL_I(IN_LEVEL_I), .OUT_COUNT_I(OUT_COUNT_I), .KEY_PRESS_I(KEY_PRESS_I),
      .FAULT_PINS_I(FAULT_PINS_I), .BAND_PINS_I(BAND_PINS_I), .SPOLL_I(sp),
      .SPOLL_DATA_O(sd), .REPLY_VALID_O(rv), .REPLY_DATA_O(rd), .SRQ_O(srq),
      .SRQ_OE_O(srq_oe), .INPUT_10V_O(in10), .OUTPUT_RANGE_O(orng), .VERBOSE_O(verb));
   bus_controller_model ctl (.clk_i(CLOCK_I), .cmd_valid_o(cv), .cmd_code_o(cc),
      .cmd_arg_o(ca), .spoll_o(sp), .reply_valid_i(rv), .reply_data_i(rd), .spoll_data_i(sd));
   ////////////////////////////////////////////////////////////////////////////
   always #5 CLOCK_I = ~CLOCK_I;
   task test_done;
      if (n_fail == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task q(input logic [4:0] c, input logic [7:0] m, input logic [7:0] e);
      ctl.ask(c, d, ok);
      chk("reply_valid", 8'h01, {7'h00, ok});
      chk("reply_data", e, d & m);
   endtask
   task pulse(input int i);
      @(negedge CLOCK_I);
      ev[i] = 1'b1;
      @(negedge CLOCK_I);
      ev = 8'h00;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_power;
      q(`CMD_ESR_QRY, 8'hFF, 8'h80);
      CE_I = 1'b0;
      ctl.send(`CMD_OPC, 16'h0000, 0);
      CE_I = 1'b1;
      q(`CMD_ESR_QRY, 8'hFF, 8'h00);
   endtask
   task t_masks;
      ctl.send(`CMD_ESE_SET, 16'h0021, 0);
      q(`CMD_ESE_QRY, 8'hFF, 8'h21);
      ctl.send(`CMD_ESE_SET, 16'h0100, 0);
      q(`CMD_ESE_QRY, 8'hFF, 8'h21);
      q(`CMD_ESR_QRY, 8'hFF, 8'h10);
      ctl.send(`CMD_SRE_SET, 16'h00FF, 0);
      q(`CMD_SRE_QRY, 8'hFF, 8'hBF);
   endtask
   task t_opc;
      ctl.send(`CMD_OPC, 16'h0000, 0);
      q(`CMD_ESR_QRY, 8'hFF, 8'h01);
      q(`CMD_OPC_QRY, 8'hFF, `OPC_REPLY);
      q(`CMD_ESR_QRY, 8'hFF, 8'h01);
   endtask
   task t_errors;
      for (int i = 0; i < 6; i++)
      begin
         pulse(i);
         q(`CMD_ESR_QRY, 8'hFF, EVX[i*8+:8]);
      end
      ctl.send(5'h1F, 16'h0000, 2);
      q(`CMD_ESR_QRY, 8'hFF, 8'h20);
      ctl.pair(`CMD_TRG, `CMD_ESR_QRY, d, ok);
      chk("reply_valid", 8'h01, {7'h00, ok});
      chk("reply_data", 8'h10, d);
   endtask
   task t_key;
      KEY_PRESS_I = 1'b1;
      repeat (4) @(negedge CLOCK_I);
      q(`CMD_ESR_QRY, 8'hFF, 8'h40);
      KEY_PRESS_I = 1'b0;
   endtask
   task t_summary;
      ctl.send(`CMD_ESE_SET, 16'h0010, 0);
      ctl.send(`CMD_SRE_SET, 16'h0020, 0);
      pulse(1);
      repeat (2) @(negedge CLOCK_I);
      chk("srq_oe", 8'h01, {7'h00, srq_oe});
      chk("srq", 8'h00, {7'h00, srq});
      q(`CMD_STB_QRY, 8'hFE, 8'h60);
      q(`CMD_ESR_QRY, 8'hFF, 8'h10);
      repeat (2) @(negedge CLOCK_I);
      chk("srq_oe", 8'h00, {7'h00, srq_oe});
   endtask
   task t_rst;
      ctl.send(`CMD_SET_INPUT, 16'h0000, 0);
      ctl.send(`CMD_SET_OUTPUT, 16'h0005, 0);
      ctl.send(`CMD_VERBOSE, 16'h0000, 0);
      chk("setup", 8'h0B, {3'h0, in10, orng, verb});
      ctl.send(`CMD_TERSE, 16'h0000, 0);
      chk("setup", 8'h0A, {3'h0, in10, orng, verb});
      ctl.send(`CMD_VERBOSE, 16'h0000, 0);
      ctl.send(`CMD_RST, 16'h0000, 1);
      chk("setup", 8'h10, {3'h0, in10, orng, verb});
      ctl.send(`CMD_SET_OUTPUT, 16'h0006, 0);
      chk("setup", 8'h10, {3'h0, in10, orng, verb});
      q(`CMD_ESR_QRY, 8'hFF, 8'h10);
      q(`CMD_ESE_QRY, 8'hFF, 8'h10);
      q(`CMD_SRE_QRY, 8'hFF, 8'h20);
   endtask
   task t_flags;
      FAULT_PINS_I = 4'hA;
      BAND_PINS_I = 3'h2;
      repeat (4) @(negedge CLOCK_I);
      q(`CMD_DER_QRY, 8'hFF, 8'h0A);
      q(`CMD_DFR_QRY, 8'hFF, 8'h02);
      pulse(6);
      ctl.poll(d);
      chk("poll", 8'h82, d & 8'h82);
      q(`CMD_STB_QRY, 8'h82, 8'h00);
   endtask
   task t_queues;
      OUT_COUNT_I = 9'h003;
      q(`CMD_STB_QRY, 8'h10, 8'h10);
      ctl.poll(d);
      chk("poll", 8'h10, d & 8'h10);
      OUT_COUNT_I = 9'h000;
      q(`CMD_STB_QRY, 8'h10, 8'h00);
      IN_LEVEL_I = 9'h0C1;
      q(`CMD_STB_QRY, 8'h08, 8'h08);
      IN_LEVEL_I = 9'h040;
      q(`CMD_STB_QRY, 8'h08, 8'h08);
      IN_LEVEL_I = 9'h03F;
      q(`CMD_STB_QRY, 8'h08, 8'h00);
      pulse(7);
      q(`CMD_STB_QRY, 8'h04, 8'h04);
      ctl.send(`CMD_CHK_QRY, 16'h0000, 0);
      q(`CMD_STB_QRY, 8'h04, 8'h00);
      pulse(7);
      q(`CMD_STB_QRY, 8'h04, 8'h00);
   endtask
   task t_tick;
      ctl.send(`CMD_TIME_QRY, 16'h0000, 0);
      q(`CMD_STB_QRY, 8'h01, 8'h00);
      repeat (3000) @(negedge CLOCK_I);
      q(`CMD_STB_QRY, 8'h01, 8'h01);
      ctl.send(`CMD_TIME_QRY, 16'h0000, 0);
      q(`CMD_STB_QRY, 8'h01, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      CLOCK_I = 1'b0;
      RSTN_I = 1'b0;
      CE_I = 1'b1;
      KEY_PRESS_I = 1'b0;
      ev = 8'h00;
      IN_LEVEL_I = 9'h000;
      OUT_COUNT_I = 9'h000;
      FAULT_PINS_I = 4'h0;
      BAND_PINS_I = 3'h0;
      repeat (12) @(posedge CLOCK_I);
      @(negedge CLOCK_I);
      RSTN_I = 1'b1;
      t_power();
      t_masks();
      t_opc();
      t_errors();
      t_key();
      t_summary();
      t_rst();
      t_flags();
      t_queues();
      t_tick();
      test_done();
   end
   initial
   begin
      #80000;
      n_fail++;
      test_done();
   end
endmodule // tb_remote_status_reporting
`default_nettype wire
